// file: logic/serial_dac_input_port.sv
/*
  Three-wire serial input port of a 16-bit converter: shift register,
  strobe-driven latch and a word FIFO in front of the converter latch.
  Assumes the host drives bit clock, strobe and data directly, and that
  the converter core accepts a word whenever dacReady is high.
  Total buffering is the FIFO depth; a latch arriving while it is
  full is dropped and flagged on overrun until the next reset.
*/
`timescale 1ns/10ps
module serial_dac_input_port #(
  parameter int WORD_BITS  = serial_dac_pkg::WORD_BITS,
  parameter int FIFO_DEPTH = serial_dac_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Host pins
  input  wire serial_dac_pkg::pins_t hostPins,
  // Converter core side
  input  wire logic                 dacReady,
  output logic [WORD_BITS-1:0]      dacWord,
  output logic                      dacUpdate,
  // Status
  output logic [WORD_BITS-1:0]      shiftWord,
  output logic                      overrun
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (WORD_BITS != 16) $error("WORD_BITS must be 16");
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH must be at least 2");
    if (serial_dac_pkg::MIN_CORE_PER_BIT < 8) $error("Core clock too slow for the bit clock");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  logic [2:0] clkSync_reg, clkSync_next;
  logic [2:0] stbSync_reg, stbSync_next;
  logic [2:0] datSync_reg, datSync_next;
  logic       clkLevel_reg, clkLevel_next;
  logic       stbLevel_reg, stbLevel_next;
  logic       clkFall, stbFall;

  // Pins arrive unrelated to core_clk, so no edge is trusted before stage three
  always_comb begin
    clkSync_next  = {clkSync_reg[1:0], hostPins.bitClk};  // see RULE1
    stbSync_next  = {stbSync_reg[1:0], hostPins.latchStrobe};
    datSync_next  = {datSync_reg[1:0], hostPins.data};
    clkLevel_next = (clkSync_reg[1] == clkSync_reg[2]) ? clkSync_reg[2] : clkLevel_reg;
    stbLevel_next = (stbSync_reg[1] == stbSync_reg[2]) ? stbSync_reg[2] : stbLevel_reg;
    clkFall       = clkLevel_reg && !clkLevel_next;  // see RULE9
    stbFall       = stbLevel_reg && !stbLevel_next;  // see RULE3
  end

  // ----------------------------------------------------------------
  // Shift register and latch
  // ----------------------------------------------------------------
  // Data takes the same three stages as the clock edge, so it is sampled while
  // still valid around the falling edge; hold time on the host is ample.
  logic [WORD_BITS-1:0] shift_reg, shift_next;
  logic [WORD_BITS-1:0] latch_reg, latch_next;
  logic                 latchLoad_reg, latchLoad_next;

  always_comb begin
    shift_next     = shift_reg;
    latch_next     = latch_reg;
    latchLoad_next = 1'b0;
    if (clkFall) begin
      shift_next = {shift_reg[WORD_BITS-2:0], datSync_reg[2]};  // see RULE9 see RULE11
    end
    if (stbFall) begin
      latch_next     = shift_reg;  // see RULE3 see RULE4 see RULE12
      latchLoad_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clkSync_reg   <= serial_dac_pkg::SYNC_RESET;
      stbSync_reg   <= serial_dac_pkg::SYNC_RESET;
      datSync_reg   <= serial_dac_pkg::SYNC_RESET;
      clkLevel_reg  <= 1'b0;
      stbLevel_reg  <= 1'b0;
      shift_reg     <= serial_dac_pkg::LATCH_RESET;
      latch_reg     <= serial_dac_pkg::LATCH_RESET;
      latchLoad_reg <= 1'b0;
    end else begin
      clkSync_reg   <= clkSync_next;
      stbSync_reg   <= stbSync_next;
      datSync_reg   <= datSync_next;
      clkLevel_reg  <= clkLevel_next;
      stbLevel_reg  <= stbLevel_next;
      shift_reg     <= shift_next;
      latch_reg     <= latch_next;
      latchLoad_reg <= latchLoad_next;
    end
  end

  // ----------------------------------------------------------------
  // Word FIFO toward the converter core
  // ----------------------------------------------------------------
  // Latched words queue so a briefly busy core loses no update
  // Limitation: a core stalled for more than FIFO_DEPTH latches drops words
  logic                 fifoInReady, fifoOutValid;
  logic [WORD_BITS-1:0] fifoOutData;

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) wordQueue (
    .core_clk (core_clk),
    .rstn     (rstn),
    .inValid  (latchLoad_reg),
    .inReady  (fifoInReady),
    .inData   (latch_reg),
    .outValid (fifoOutValid),
    .outReady (dacReady),
    .outData  (fifoOutData)
  );

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Word is passed unchanged: twos complement, zero is midscale
  // Overrun is sticky so a single lost update is never missed by software
  logic [WORD_BITS-1:0] dacWord_reg, dacWord_next;
  logic                 dacUpdate_reg, dacUpdate_next;
  logic                 overrun_reg, overrun_next;

  always_comb begin
    dacWord_next   = dacWord_reg;
    dacUpdate_next = 1'b0;
    overrun_next   = overrun_reg || (latchLoad_reg && !fifoInReady);
    if (fifoOutValid && dacReady) begin
      dacWord_next   = fifoOutData;  // see RULE10 see RULE7
      dacUpdate_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dacWord_reg   <= serial_dac_pkg::LATCH_RESET;
      dacUpdate_reg <= 1'b0;
      overrun_reg   <= 1'b0;
    end else begin
      dacWord_reg   <= dacWord_next;
      dacUpdate_reg <= dacUpdate_next;
      overrun_reg   <= overrun_next;
    end
  end

  assign dacWord   = dacWord_reg;
  assign dacUpdate = dacUpdate_reg;
  assign shiftWord = shift_reg;
  assign overrun   = overrun_reg;

  // ----------------------------------------------------------------
  // Checks: link side
  // ----------------------------------------------------------------
  chk_shift_on_fall: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE9
    clkFall |=> shift_reg == {$past(shift_reg[WORD_BITS-2:0]), $past(datSync_reg[2])})
    else $error("shift register did not take bit on falling clock");
  chk_shift_hold: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE11
    !clkFall |=> $stable(shift_reg))
    else $error("shift register moved without a clock edge");
  chk_latch_load: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE3
    stbFall |=> latch_reg == $past(shift_reg) && latchLoad_reg)
    else $error("latch did not load on strobe fall");
  chk_latch_prev_word: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE4
    (stbFall && clkFall) |=> latch_reg == $past(shift_reg))
    else $error("latch took the word being started");
  chk_latch_hold: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE12
    !stbFall |=> $stable(latch_reg))
    else $error("latch changed between strobe falls");
  // Filter: a pin change counts only once stages two and three agree
  chk_clk_filter: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE9
    (clkSync_reg[1] != clkSync_reg[2]) |=> $stable(clkLevel_reg))
    else $error("bit clock level moved while stages disagreed");
  chk_stb_filter: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE3
    (stbSync_reg[1] != stbSync_reg[2]) |=> $stable(stbLevel_reg))
    else $error("strobe level moved while stages disagreed");
  chk_load_on_fall: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE3
    !stbFall |=> !latchLoad_reg)
    else $error("latch load without strobe fall");
  chk_queue_accept: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE3
    (latchLoad_reg && fifoInReady) |-> ##2 fifoOutValid)
    else $error("accepted word not offered to the core");

  // ----------------------------------------------------------------
  // Checks: converter side
  // ----------------------------------------------------------------
  chk_output_word: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE10
    (fifoOutValid && dacReady) |=> dacUpdate && dacWord == $past(fifoOutData))
    else $error("converter word not passed unchanged");
  chk_no_loss: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE7
    (latchLoad_reg && dacReady) |-> fifoInReady)
    else $error("update lost with core ready");
  chk_update_pulse: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE7
    stbFall |-> ##[2:3] fifoOutValid || !dacReady)
    else $error("latched word did not reach the core in time");
  chk_update_source: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE7
    dacUpdate_reg |-> $past(fifoOutValid && dacReady))
    else $error("update pulse without a handed word");
  chk_word_hold: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE12
    !(fifoOutValid && dacReady) |=> $stable(dacWord_reg) && !dacUpdate_reg)
    else $error("converter word changed without a hand-over");
  chk_stall_keep: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE7
    (fifoOutValid && !dacReady) |=> fifoOutValid && $stable(fifoOutData))
    else $error("queued word lost while core stalled");
  // Overrun only rises on a refused load and never falls until reset
  chk_overrun_sticky: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE7
    overrun_reg |=> overrun_reg)
    else $error("overrun flag cleared itself");
  chk_overrun_cause: assert property (@(posedge core_clk) disable iff (!rstn)  // see RULE7
    (!overrun_reg && !(latchLoad_reg && !fifoInReady)) |=> !overrun_reg)
    else $error("overrun set without a dropped word");
endmodule

// file: logic/serial_dac_pkg.sv
/*
  Constants and carrier types for the serial converter input port.
  Assumes a single core clock domain; all pins arrive asynchronously.
*/
// Functional notes
// RULE1: Host clock, strobe and data pins wire straight to the port's bit-clock, latch-strobe and data inputs.
// RULE2: The host keeps each data bit valid at the falling bit-clock edge where it is sampled.
// RULE3: After a full 16-bit word is shifted, a falling latch-strobe edge loads that word into the latch.
// RULE4: In continuous mode the strobe falling at a word's start latches the word shifted before it.
// RULE5: The port accepts host bit clocks from 94 Hz to 6.25 MHz.
// RULE6: The port accepts a bit clock of up to a quarter of the host oscillator rate.
// RULE7: Latched updates at 500 kSPS are accepted without loss or corruption.
// RULE8: Two host ports may drive two separate converters, each with its own three lines.
// RULE9: Data shifts in on each falling bit-clock edge, sign bit first.
// RULE10: Each word is twos complement, with all zeros meaning midscale.
// RULE11: The shift register always shows the 16 most recent bits; older bits fall away.
// RULE12: The input latch holds its value between falling latch-strobe edges.
package serial_dac_pkg;

  localparam int WORD_BITS = 16;
  localparam int SYNC_STAGES = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int CORE_CLK_HZ = 125000000;
  localparam int MAX_BIT_CLK_HZ = 6250000;
  localparam int MIN_CORE_PER_BIT = CORE_CLK_HZ / MAX_BIT_CLK_HZ;
  localparam int UPDATE_RATE_SPS = 500000;
  localparam int UPDATE_CYCLES = CORE_CLK_HZ / UPDATE_RATE_SPS;

  localparam logic [WORD_BITS-1:0] LATCH_RESET = 16'h0000;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef struct packed {
    logic bitClk;
    logic latchStrobe;
    logic data;
  } pins_t;

  typedef enum logic [1:0] {
    DRAIN_IDLE = 2'b00,
    DRAIN_LOAD = 2'b01
  } drain_t;

endpackage

// file: logic/word_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; read data come from a register.
*/
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [WIDTH-1:0] outData_reg, outData_next;
  logic             outValid_reg, outValid_next;
  logic             memEmpty, memFull, doWrite, doRead;
  logic [AW+1:0]    fill;

  always_comb begin
    memEmpty      = wrPtr_reg == rdPtr_reg;
    // Output register counts as one of the DEPTH slots
    fill          = {1'b0, wrPtr_reg - rdPtr_reg} + {{(AW+1){1'b0}}, outValid_reg};
    memFull       = fill >= (AW+2)'(DEPTH);
    doWrite       = inValid && !memFull;
    doRead        = !memEmpty && (!outValid_reg || outReady);
    wrPtr_next    = doWrite ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next    = doRead ? rdPtr_reg + 1'b1 : rdPtr_reg;
    outData_next  = doRead ? mem[rdPtr_reg[AW-1:0]] : outData_reg;
    outValid_next = doRead || (outValid_reg && !outReady);
  end

  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg    <= '0;
      rdPtr_reg    <= '0;
      outData_reg  <= '0;
      outValid_reg <= 1'b0;
    end else begin
      wrPtr_reg    <= wrPtr_next;
      rdPtr_reg    <= rdPtr_next;
      outData_reg  <= outData_next;
      outValid_reg <= outValid_next;
    end
  end

  assign inReady  = !memFull;
  assign outValid = outValid_reg;
  assign outData  = outData_reg;
endmodule

// file: testbench/host_serial_tx.sv
/*
  Behavioural host serial transmit port driving the port's three pins.
  Assumes the bench calls its tasks one at a time, never overlapping.
*/
`timescale 1ns/10ps
module host_serial_tx #(
  parameter int HALF_NS = 80
) (
  // Pins toward the port
  output serial_dac_pkg::pins_t hostPins
);
  // --------------------------------------------------------------
  // Idle: clock parked high, strobe high
  // --------------------------------------------------------------
  initial hostPins = 3'h6;

  // Data set at the rising edge, so it is steady across the fall
  task automatic send_word(input logic [15:0] w, input logic framed);
    for (int i = 15; i >= 0; i--) begin
      hostPins.data = w[i];
      hostPins.latchStrobe = 1'b1;
      #HALF_NS;
      hostPins.bitClk = 1'b0;
      // Frame sync falls with the word's first clock edge
      hostPins.latchStrobe = !(framed && i == 15);
      #HALF_NS;
      hostPins.bitClk = 1'b1;
    end
    // Released line must not look like the last bit
    hostPins.data = ~w[0];
    // Clock parked so the next call starts in a later time step
    #HALF_NS;
  endtask

  task automatic strobe_fall;
    hostPins.latchStrobe = 1'b0;
    #(2 * HALF_NS);
    hostPins.latchStrobe = 1'b1;
    #(2 * HALF_NS);
  endtask
endmodule

// file: testbench/testbench.sv
/*
  Self-checking bench for the serial converter input port.
  Assumes the host model alone drives the pins; the bench drives dacReady.
*/
`timescale 1ns/10ps
module testbench;
  logic                  core_clk;
  logic                  rstn;
  logic                  dacReady;
  serial_dac_pkg::pins_t hostPins;
  logic [15:0]           dacWord;
  logic                  dacUpdate;
  logic [15:0]           shiftWord;
  logic                  overrun;
  logic [15:0]           gotQ[$];
  int                    err_total;
  int                    check_count;

  host_serial_tx u_host (.hostPins(hostPins));
  serial_dac_input_port u_dut (
    .core_clk(core_clk), .rstn(rstn), .hostPins(hostPins), .dacReady(dacReady),
    .dacWord(dacWord), .dacUpdate(dacUpdate), .shiftWord(shiftWord), .overrun(overrun));

  // --------------------------------------------------------------
  // Clock, word capture and helpers
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (dacUpdate === 1'b1) gotQ.push_back(dacWord);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait for n captured words
  task automatic wait_words(input int n);
    for (int k = 0; k < 3000 && gotQ.size() < n; k++) @(posedge core_clk);
    if (gotQ.size() < n) begin
      err_total++;
      test_done();
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_single;
    logic [15:0] tbl[3];
    tbl = '{16'h8001, 16'h7fff, 16'h0000};
    foreach (tbl[i]) begin
      u_host.send_word(tbl[i], 1'b0);
      u_host.strobe_fall();
      wait_words(1);
      check(gotQ.pop_front(), tbl[i]);
      check(shiftWord, tbl[i]);
    end
    $display("test_single done");
  endtask

  task automatic test_extra;
    u_host.send_word(16'ha5a5, 1'b0);
    u_host.send_word(16'h1234, 1'b0);
    u_host.strobe_fall();
    wait_words(1);
    check(gotQ.pop_front(), 16'h1234);
    $display("test_extra done");
  endtask

  task automatic test_continuous;
    u_host.send_word(16'h1111, 1'b1);
    u_host.send_word(16'h2222, 1'b1);
    u_host.send_word(16'h3333, 1'b1);
    wait_words(3);
    check(gotQ.pop_front(), 16'h1234);
    check(gotQ.pop_front(), 16'h1111);
    check(gotQ.pop_front(), 16'h2222);
    $display("test_continuous done");
  endtask

  task automatic test_hold;
    u_host.send_word(16'hbeef, 1'b0);
    repeat (10) @(posedge core_clk);
    check(16'(gotQ.size()), 16'h0000);
    check(dacWord, 16'h2222);
    check(shiftWord, 16'hbeef);
    $display("test_hold done");
  endtask

  // Nine latches into an eight-word buffer with the core stalled
  task automatic test_fifo;
    @(posedge core_clk) #1 dacReady = 1'b0;
    for (int i = 0; i < 9; i++) begin
      u_host.send_word(16'h0100 + 16'(i), 1'b0);
      u_host.strobe_fall();
    end
    check({15'h0000, overrun}, 16'h0001);
    check(16'(gotQ.size()), 16'h0000);
    @(posedge core_clk) #1 dacReady = 1'b1;
    wait_words(8);
    for (int i = 0; i < 8; i++) check(gotQ.pop_front(), 16'h0100 + 16'(i));
    repeat (4) @(posedge core_clk);
    check(16'(gotQ.size()), 16'h0000);
    $display("test_fifo done");
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    err_total = 0;
    check_count = 0;
    rstn = 1'b0;
    dacReady = 1'b1;
    repeat (12) @(posedge core_clk);
    check(dacWord, 16'h0000);
    check(shiftWord, 16'h0000);
    check({15'h0000, overrun}, 16'h0000);
    #1 rstn = 1'b1;
    repeat (4) @(posedge core_clk);
    test_single();
    test_extra();
    test_continuous();
    test_hold();
    test_fifo();
    test_done();
  end
endmodule
